// File: design/ecp_capture_pwm.sv
`timescale 1ns/1ps
// Operation
// - capture counter value on each qualified rising event edge
// - one mode bit selects capture or PWM
// - PWM counter counts up only
// - reg one period, reg two compare
// - reg three, four shadow period, compare
// - one shared four-register set both modes
// - counter takes sync input, drives sync output
// - all events merge onto one interrupt
// - clock gate bit halts all of the channel but the flag clear, interrupt and pin qualifiers
module ecp_capture_pwm (
    input wire logic i_clk, // subsystem clock, 125 MHz
    input wire logic i_reset_n, // async reset, active low
    input wire logic i_clk_enable, // system control clock gate bit
    input wire logic i_capture_pwm_select, // 0 capture, 1 auxiliary pwm
    input wire logic i_event_pin, // external capture event pin
    input wire logic i_sync_input, // sync from neighbour module
    input wire logic i_sync_in_enable, // accept sync input
    input wire logic i_sync_out_enable, // drive sync output on wrap or sync
    input wire logic [31:0] i_phase, // counter load value on sync
    input wire logic i_wr_en, // one-cycle write strobe for shared registers
    input wire logic [1:0] i_wr_sel, // register index 0..3
    input wire logic [31:0] i_wr_data, // write data
    input wire logic [3:0] i_int_enable, // per-event interrupt enables
    input wire logic [3:0] i_flag_clear, // one-cycle clear of event flags
    output logic [31:0] o_counter, // running counter
    output logic [31:0] o_capture_reg_one, // shared register one
    output logic [31:0] o_capture_reg_two, // shared register two
    output logic [31:0] o_capture_reg_three, // shared register three
    output logic [31:0] o_capture_reg_four, // shared register four
    output logic [1:0] o_capture_ptr, // next capture slot
    output logic o_pwm_out, // auxiliary pwm output
    output logic o_sync_output, // sync pulse to neighbours
    output logic [3:0] o_flags, // sticky event flags
    output logic o_channel_event_interrupt // interrupt to the interrupt expander
);
    typedef struct packed {
        ecp_pkg::ecp_mode_type mode;
        logic [31:0] cnt;
        logic [3:0][31:0] regs;
        logic [1:0] ptr;
        logic pwm;
        logic [3:0] sync_cnt;
        logic [3:0] flags;
        logic irq;
    } ecp_state_type;

    ecp_state_type st_q;
    ecp_state_type st_d;

    // how the channel behaves, cycle by cycle
    //
    // capture mode:
    // - the counter runs free from reset and wraps after all ones
    // - the wrap sets the overflow flag and may start a sync pulse
    // - a qualified rise of the event pin copies the counter into
    //   the slot that the capture pointer names, then the pointer
    //   moves on; slots fill zero, one, two, three and round again
    // - the pin crosses three flops, so the stored value lags the
    //   pin edge by a few cycles; software that measures intervals
    //   sees the same lag on every event, so differences stay exact
    // - a pulse shorter than two cycles may be missed by the qualifier
    //
    // auxiliary pwm mode:
    // - register one holds the active period, register two the
    //   active compare, registers three and four their shadows
    // - the counter climbs from zero to the period and then restarts,
    //   so one period lasts period plus one cycles
    // - the output is high from the restart until the counter
    //   reaches the compare value; compare zero keeps it low,
    //   compare above the period keeps it high
    // - shadows move into the active pair only on the restart, so a
    //   shadow pair written within one period never reaches the waveform half-written
    // - a write to the active pair that lands on the restart cycle
    //   loses to the shadow load; software should write the shadows
    //
    // both modes:
    // - the same four storage words are used; switching mode keeps
    //   their contents, so a captured value may become a period
    // - the mode register follows the select pin one cycle later,
    //   which keeps the case decode and the pin from racing
    // - an accepted sync input loads the phase word into the counter
    //   and wins over both counting and the pwm restart
    // - flags are sticky; a clear pulse drops them, but an event in
    //   the same cycle keeps its flag set, so no event is lost
    // - the interrupt is the registered or of enabled next flags
    // - with the clock gate low everything but the flag clear, the interrupt and the pin qualifiers holds;
    //   pin edges seen while gated are dropped, not queued

    logic evt_rise;
    logic sync_rise;

    // pins from outside cross through the three-stage qualifier
    ecp_sync3 u_evt_sync (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_pin(i_event_pin),
        .o_level(),
        .o_rise(evt_rise)
    );

    ecp_sync3 u_sync_sync (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_pin(i_sync_input),
        .o_level(),
        .o_rise(sync_rise)
    );

    // one-hot select of a register in the shared set, used for write and capture
    function automatic logic [3:0] slot_hit(input logic [1:0] idx);
        slot_hit = 4'h1 << idx;
    endfunction

    logic [3:0] ev_set;
    logic wrap;
    logic do_sync;
    logic cmp_hit;
    logic [3:0] wr_hit;
    logic [3:0] cap_hit;

    always_comb begin
        st_d = st_q;
        ev_set = 4'h0;
        wrap = 1'b0;
        cmp_hit = 1'b0;
        wr_hit = i_wr_en ? slot_hit(i_wr_sel) : 4'h0;
        cap_hit = 4'h0;
        do_sync = i_sync_in_enable & sync_rise;
        // gated clock: all but the flag clear and interrupt holds, no events, no writes
        if (i_clk_enable) begin
            st_d.mode = i_capture_pwm_select ? ecp_pkg::ECP_MODE_PWM
                                             : ecp_pkg::ECP_MODE_CAP;
            case (st_q.mode)
                ecp_pkg::ECP_MODE_CAP: begin
                    // free-running counter, rollover reported as overflow
                    st_d.cnt = st_q.cnt + 32'h0000_0001;
                    if (st_q.cnt == 32'hFFFF_FFFF) begin
                        ev_set[ecp_pkg::FLG_OVF] = 1'b1;
                        wrap = 1'b1;
                    end
                    if (evt_rise) begin
                        cap_hit = slot_hit(st_q.ptr);
                        st_d.ptr = st_q.ptr + 2'h1;
                        ev_set[ecp_pkg::FLG_CAP] = 1'b1;
                    end
                end
                ecp_pkg::ECP_MODE_PWM: begin
                    // up-count only; a count at or above the period restarts the cycle
                    if (st_q.cnt >= st_q.regs[0]) begin
                        st_d.cnt = ecp_pkg::CNT_RST;
                        wrap = 1'b1;
                        ev_set[ecp_pkg::FLG_PRD] = 1'b1;
                        // shadow transfer only at the boundary avoids glitches
                        st_d.regs[0] = st_q.regs[2];
                        st_d.regs[1] = st_q.regs[3];
                    end else begin
                        st_d.cnt = st_q.cnt + 32'h0000_0001;
                    end
                    cmp_hit = (st_q.cnt == st_q.regs[1]);
                    if (cmp_hit) begin
                        ev_set[ecp_pkg::FLG_CMP] = 1'b1;
                    end
                    // high from period start until compare match
                    st_d.pwm = (st_d.cnt < st_d.regs[1]);
                end
                default: begin
                    st_d.mode = ecp_pkg::ECP_MODE_CAP;
                end
            endcase
            // sync input loads the phase value, taking priority over counting
            if (do_sync) begin
                st_d.cnt = i_phase;
            end
            // same four storage words serve both modes
            for (int i = 0; i < 4; i++) begin
                if (cap_hit[i]) begin
                    st_d.regs[i] = st_q.cnt;
                end else if (wr_hit[i]
                             && !(wrap && st_q.mode == ecp_pkg::ECP_MODE_PWM
                                  && i < 2)) begin
                    st_d.regs[i] = i_wr_data;
                end
            end
            if (st_q.mode == ecp_pkg::ECP_MODE_CAP) begin
                st_d.pwm = 1'b0;
            end
            // sync output stretched so neighbours see it on their own qualifiers
            if (i_sync_out_enable && (wrap || do_sync)) begin
                st_d.sync_cnt = ecp_pkg::SYNC_OUT_LEN;
            end else if (st_q.sync_cnt != 4'h0) begin
                st_d.sync_cnt = st_q.sync_cnt - 4'h1;
            end
        end
        // set wins over clear so no event is lost
        st_d.flags = (st_q.flags & ~i_flag_clear) | ev_set;
        st_d.irq = |(st_d.flags & i_int_enable);
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_q.mode <= ecp_pkg::ECP_MODE_CAP;
            st_q.cnt <= ecp_pkg::CNT_RST;
            st_q.regs <= {4{ecp_pkg::REG_RST}};
            st_q.ptr <= 2'h0;
            st_q.pwm <= 1'b0;
            st_q.sync_cnt <= 4'h0;
            st_q.flags <= 4'h0;
            st_q.irq <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from state flops, except sync output, the nonzero decode of the stretch count
    assign o_counter = st_q.cnt;
    assign o_capture_reg_one = st_q.regs[0];
    assign o_capture_reg_two = st_q.regs[1];
    assign o_capture_reg_three = st_q.regs[2];
    assign o_capture_reg_four = st_q.regs[3];
    assign o_capture_ptr = st_q.ptr;
    assign o_pwm_out = st_q.pwm;
    assign o_sync_output = (st_q.sync_cnt != 4'h0);
    assign o_flags = st_q.flags;
    assign o_channel_event_interrupt = st_q.irq;
endmodule

// File: design/ecp_pkg.sv
package ecp_pkg;
    // counter and capture width
    localparam int CNT_W = 32;
    // reset values
    localparam logic [31:0] CNT_RST = 32'h0000_0000;
    localparam logic [31:0] REG_RST = 32'h0000_0000;
    // sync output pulse length in clock cycles
    localparam int SYNC_OUT_CYC = 8;
    localparam logic [3:0] SYNC_OUT_LEN = 4'h8;
    // interrupt flag positions
    localparam int FLG_CAP = 0;
    localparam int FLG_PRD = 1;
    localparam int FLG_CMP = 2;
    localparam int FLG_OVF = 3;
    localparam int FLG_W = 4;
    // operating modes
    typedef enum logic [1:0] {
        ECP_MODE_CAP = 2'b01,
        ECP_MODE_PWM = 2'b10
    } ecp_mode_type;
endpackage

// File: design/ecp_sync3.sv
`timescale 1ns/1ps
// three-stage pin synchroniser; a change counts once stages two and three agree
module ecp_sync3 (
    input wire logic i_clk, // system clock
    input wire logic i_reset_n, // async reset, active low
    input wire logic i_pin, // asynchronous pin
    output logic o_level, // qualified level
    output logic o_rise // one-cycle pulse on qualified rise
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } ecp_sync_type;
    ecp_sync_type st_q;
    ecp_sync_type st_d;

    // stage one feeds only stage two
    always_comb begin
        st_d = st_q;
        st_d.s1 = i_pin;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        if (st_q.s2 == st_q.s3) begin
            st_d.lvl = st_q.s3;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_level = st_q.lvl;
    assign o_rise = st_d.lvl & ~st_q.lvl;
endmodule

// File: test/ecp_capture_pwm_assertions.sv
`timescale 1ns/1ps
// port-level checks of the channel
module ecp_chk (
    input wire logic i_clk, // clock
    input wire logic i_reset_n, // reset, low
    input wire logic i_clk_enable, // gate
    input wire logic i_capture_pwm_select, // mode pin
    input wire logic i_sync_in_enable, // sync accept
    input wire logic [3:0] i_int_enable, // mask
    input wire logic [31:0] o_counter, // counter
    input wire logic [31:0] o_capture_reg_one, // reg one
    input wire logic [31:0] o_capture_reg_two, // reg two
    input wire logic [31:0] o_capture_reg_three, // reg three
    input wire logic [31:0] o_capture_reg_four, // reg four
    input wire logic [1:0] o_capture_ptr, // slot
    input wire logic o_sync_output, // sync out
    input wire logic [3:0] o_flags, // flags
    input wire logic o_channel_event_interrupt // irq
);
    logic mode_q;
    logic [31:0] slot [4];
    // mode register copy, it lags the pin by one enabled cycle
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) mode_q <= 1'h0;
        else if (i_clk_enable) mode_q <= i_capture_pwm_select;
    end
    // index the shared set by slot number
    always_comb slot = '{o_capture_reg_one, o_capture_reg_two,
        o_capture_reg_three, o_capture_reg_four};
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    sequence s_top; mode_q && i_clk_enable && !i_sync_in_enable; endsequence
    sequence s_hold8; o_sync_output [*8] ##1 !o_sync_output; endsequence
    a_irq_from_flags: assert property (
        o_channel_event_interrupt == |(o_flags & $past(i_int_enable))) else $error("irq");
    a_gate_counter: assert property (
        !i_clk_enable |=> $stable(o_counter)) else $error("gated count");
    a_gate_capture: assert property (
        !i_clk_enable |=> $stable(o_capture_ptr) && $stable(o_capture_reg_one))
        else $error("gated");
    a_pwm_count_up: assert property (
        s_top and o_counter < o_capture_reg_one |=> o_counter == $past(o_counter) + 32'h1)
        else $error("count up");
    a_period_wrap: assert property (
        s_top and o_counter == o_capture_reg_one |=> o_counter == 32'h0
        && o_capture_reg_one == $past(o_capture_reg_three)
        && o_capture_reg_two == $past(o_capture_reg_four)) else $error("wrap");
    a_capture_slot: assert property (
        !mode_q && !i_capture_pwm_select && $changed(o_capture_ptr) |->
        o_capture_ptr == $past(o_capture_ptr) + 2'h1
        && slot[$past(o_capture_ptr)] == $past(o_counter)) else $error("capture");
    a_sync_out_len: assert property (
        $rose(o_sync_output) |-> s_hold8) else $error("sync length");
    a_cmp_flag_set: assert property (
        mode_q && i_clk_enable && o_counter == o_capture_reg_two |=> o_flags[2])
        else $error("compare flag");
endmodule
bind ecp_capture_pwm ecp_chk chk (.*);

// File: test/ecp_peer.sv
`timescale 1ns/1ps
// event source and neighbouring timer, both lines idle low
module ecp_peer (
    input wire logic i_clk, // clock
    output logic o_event_pin, // event line
    output logic o_sync_pin // neighbour sync line
);
    initial begin
        o_event_pin = 1'h0;
        o_sync_pin = 1'h0;
    end
    // held four cycles, twice the qualifier minimum, then quiet four
    task automatic fire(input logic sync_line);
        @(posedge i_clk);
        if (sync_line) o_sync_pin <= 1'h1;
        else o_event_pin <= 1'h1;
        repeat (4) @(posedge i_clk);
        o_sync_pin <= 1'h0;
        o_event_pin <= 1'h0;
        repeat (4) @(posedge i_clk);
    endtask
endmodule

// File: test/test_event_capture_aux_pwm.sv
`timescale 1ns/1ps
// integer model of pwm period, duty and capture delay
module test_event_capture_aux_pwm;
    logic i_clk = 1'h0, i_reset_n = 1'h0, en = 1'h1, sel = 1'h0, se = 1'h0, wr = 1'h0;
    logic ev, sy, pwm, so, irq;
    logic [1:0] ws = 2'h0, ptr;
    logic [3:0] ie = 4'h0, clr = 4'h0, flg;
    logic [31:0] ph = 32'h0, wd = 32'h0, lf = 32'hE5B994DE, cnt, r [4];
    int fail_count = 0, comparisons = 0, cyc = 0, t0, t1, pp, cc, per, hi;
    always #4 i_clk = ~i_clk;
    ecp_peer p (.i_clk(i_clk), .o_event_pin(ev), .o_sync_pin(sy));
    ecp_capture_pwm uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_clk_enable(en),
        .i_capture_pwm_select(sel), .i_event_pin(ev), .i_sync_input(sy),
        .i_sync_in_enable(se), .i_sync_out_enable(se), .i_phase(ph), .i_wr_en(wr),
        .i_wr_sel(ws), .i_wr_data(wd), .i_int_enable(ie), .i_flag_clear(clr),
        .o_counter(cnt), .o_capture_reg_one(r[0]), .o_capture_reg_two(r[1]),
        .o_capture_reg_three(r[2]), .o_capture_reg_four(r[3]), .o_capture_ptr(ptr),
        .o_pwm_out(pwm), .o_sync_output(so), .o_flags(flg), .o_channel_event_interrupt(irq));
    function automatic logic [31:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction
    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'h1) begin
            fail_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic wrt(input logic [1:0] s, input logic [31:0] d);
        @(posedge i_clk);
        wr <= 1'h1;
        ws <= s;
        wd <= d;
        @(posedge i_clk);
        wr <= 1'h0;
    endtask
    // one period from wrap to wrap; sampled at the falling edge so values are settled
    task automatic period();
        per = 0;
        hi = 0;
        @(negedge i_clk);
        for (int k = 0; k < 300 && cnt !== 32'h0; k++) @(negedge i_clk);
        do begin
            hi += int'(pwm === 1'h1);
            per++;
            @(negedge i_clk);
        end while (cnt !== 32'h0 && per < 300);
    endtask
    task automatic stop_test();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // the run needs well under a thousand cycles; this ceiling only catches a hang
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            stop_test();
        end
    end
    // pwm first, while the free count is still below the period
    initial begin
        repeat (12) @(posedge i_clk);
        i_reset_n <= 1'h1;
        for (int j = 0; j < 2; j++) begin
            pp = 40 + rnd() % 40;
            cc = 1 + rnd() % pp;
            wrt(2'h2, 32'(pp));
            wrt(2'h3, 32'(cc));
            if (j == 0) begin
                wrt(2'h0, 32'(pp));
                wrt(2'h1, 32'(cc));
                sel <= 1'h1;
            end
            repeat (2) period();
            chk(per == pp + 1 && hi == cc, "pwm period or duty");
            chk(r[0] === 32'(pp) && r[1] === 32'(cc) && flg[2:1] === 2'h3, "active");
        end
        @(posedge i_clk);
        sel <= 1'h0;
        ie <= 4'h1;
        repeat (3) @(negedge i_clk);
        t1 = ptr;
        for (int k = 1; k < 6; k++) begin
            @(negedge i_clk);
            t0 = cnt;
            p.fire(1'h0);
            @(negedge i_clk);
            per = r[(t1 + k - 1) % 4] - t0;
            chk(per > 3 && per < 8, "capture value");
            chk(ptr === 2'(t1 + k) && flg[0] === 1'h1 && irq === 1'h1, "slot");
        end
        @(posedge i_clk);
        clr <= 4'hF;
        @(posedge i_clk);
        clr <= 4'h0;
        @(negedge i_clk);
        chk(flg === 4'h0 && irq === 1'h0, "flag clear");
        @(posedge i_clk);
        en <= 1'h0;
        @(negedge i_clk);
        t0 = cnt;
        p.fire(1'h0);
        @(negedge i_clk);
        chk(cnt === t0 && ptr === 2'(t1 + 5), "gated channel moved");
        @(posedge i_clk);
        en <= 1'h1;
        ph <= rnd() >> 1;
        se <= 1'h1;
        p.fire(1'h1);
        @(negedge i_clk);
        per = cnt - ph;
        chk(per > 1 && per < 8, "sync load");
        chk(so === 1'h1, "sync out missing");
        repeat (4) @(negedge i_clk);
        chk(so === 1'h0, "sync out too long");
        @(posedge i_clk);
        ph <= 32'hFFFF_FFF0;
        p.fire(1'h1);
        repeat (16) @(negedge i_clk);
        chk(flg[3] === 1'h1 && cnt < 32'h8 && so === 1'h1, "overflow");
        stop_test();
    end
endmodule
